// ==== core/i2cee_map.svh ====
// Constants of the two-wire serial EEPROM slave engine
`ifndef I2CEE_MAP_SVH
`define I2CEE_MAP_SVH

// Slave address
`define I2CEE_TYPE_CODE 4'ha

// Array organisation
`define I2CEE_ADDR_W 15
`define I2CEE_OFS_W 6
`define I2CEE_PAGE_W 9
`define I2CEE_GRP_AW 13
`define I2CEE_GRP_BYTES 4
`define I2CEE_GRP_W 32
`define I2CEE_ECC_W 6
`define I2CEE_CODE_LEN 38
`define I2CEE_ERASED_GRP 32'hffffffff

// Write buffer FIFO entry: in-page offset and data byte
`define I2CEE_FIFO_W 14
`define I2CEE_FIFO_DEPTH 32

// Timing
`define I2CEE_CLK_KHZ 200000
`define I2CEE_T_WR_MS 5
`define I2CEE_WR_CYCLES (`I2CEE_T_WR_MS * `I2CEE_CLK_KHZ)

// Pin reset levels: bus lines idle high, straps low
`define I2CEE_PIN_RST 6'h03

`endif

// ==== core/i2cee_pkg.sv ====
// Types of the two-wire serial EEPROM slave engine
package i2cee_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_AHI  = 3'h3,
    ST_ALO  = 3'h2,
    ST_WDAT = 3'h6,
    ST_RDAT = 3'h7,
    ST_HOLD = 3'h5
  } i2cee_bus_st_t;

  typedef enum logic [2:0] {
    PG_IDLE  = 3'h0,
    PG_DRAIN = 3'h1,
    PG_RD    = 3'h3,
    PG_MRG   = 3'h2,
    PG_WAIT  = 3'h6
  } i2cee_prog_st_t;

endpackage

// ==== core/i2cee_fifo_if.sv ====
// Valid/ready carrier between the bus engine and the write buffer FIFO
`timescale 1ns/100ps
`default_nettype none
`include "i2cee_map.svh"

interface i2cee_fifo_if #(parameter int W = `I2CEE_FIFO_W);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport fill (output push_valid, push_data, input push_ready);
  modport drain (output pop_ready, input pop_valid, pop_data);
endinterface

`default_nettype wire

// ==== core/i2cee_fifo.sv ====
// Parameterised write buffer FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module i2cee_fifo #(
  parameter int W = 14,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Both FIFO sides
  i2cee_fifo_if.store f
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire do_push = f.push_valid && !full;
  wire do_pop = f.pop_ready && !empty;

  assign f.push_ready = !full;
  assign f.pop_valid = !empty;
  assign f.pop_data = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Storage carries no reset; only the pointers define content
  always_ff @(posedge ref_clk_i) begin
    if (do_push) mem[wr_ptr_r[AW-1:0]] <= f.push_data;
  end

endmodule

`default_nettype wire

// ==== core/i2cee_top.sv ====
// Two-wire serial EEPROM slave engine with ECC-protected array
// Notes on behaviour
// - Held in reset while power-on reset is low; standby once released.
// - Sample SDA at SCL rise, change driven SDA at SCL fall, open-drain.
// - Zero is sent by pulling SDA low, one by releasing it.
// - SDA fall with SCL high is START, SDA rise with SCL high is STOP.
// - Everything is ignored until a START is seen.
// - STOP after write launches program cycle; STOP after read returns standby.
// - Slave address matches type 1010 and strap levels; last bit selects read.
// - Acknowledge matching address, address bytes and write data in ninth clock.
// - Read: shift byte, release SDA at ninth clock, continue on master ACK.
// - No address acknowledge while the program cycle runs.
// - Address top bit ignored; 9 page bits, 6 byte-in-page bits.
// - Write position increments per data byte and wraps inside the page.
// - Write protect sampled at fall before first data byte; high rejects write.
// - High write protect blocks all writes; low or open has no effect.
// - Address counter points past last byte accessed, wrapping to zero.
// - Read address acknowledged, then byte at the counter is sent.
// - Sequential read keeps incrementing while acknowledged, wrapping at end.
// - Array starts fully erased to FFh.
// - Six check bits per four-byte group; a byte write reprograms its group.
`timescale 1ns/100ps
`default_nettype none
`include "i2cee_map.svh"

module i2cee_top #(
  parameter int WR_CYC = `I2CEE_WR_CYCLES
) (
  // Clock and power-on reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps
  input wire logic chip_select_inputs_i,
  input wire logic chip_select_inputs_mid_i,
  input wire logic chip_select_inputs_top_i,
  input wire logic write_protect_input_i,
  // Status
  output logic write_busy_o
);

  localparam logic [19:0] WR_LAST = 20'(WR_CYC - 1);

  function automatic logic [5:0] ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= `I2CEE_CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) c = c ^ 6'(p);
        k++;
      end
    end
    return c;
  endfunction

  // Single-bit data errors are corrected; check-bit errors need no repair
  function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] chk);
    logic [5:0] syn;
    logic [31:0] r;
    int k;
    syn = chk ^ ecc_gen(d);
    r = d;
    k = 0;
    for (int p = 1; p <= `I2CEE_CODE_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == 6'(p)) r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [5:0] s1_r, s2_r, s3_r, pin_r;
  logic scl_d_r, sda_d_r;
  wire [5:0] raw = {write_protect_input_i, chip_select_inputs_top_i, chip_select_inputs_mid_i,
                    chip_select_inputs_i, sda_i, scl_i};
  wire [5:0] agree = ~(s2_r ^ s3_r);
  wire [5:0] pin_nxt = (agree & s3_r) | (~agree & pin_r);
  wire scl = pin_r[0];
  wire sda = pin_r[1];
  wire [2:0] cs_strap = pin_r[4:2];
  wire wp_pin = pin_r[5];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_r <= `I2CEE_PIN_RST;
      s2_r <= `I2CEE_PIN_RST;
      s3_r <= `I2CEE_PIN_RST;
      pin_r <= `I2CEE_PIN_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  wire scl_rise = scl && !scl_d_r;
  wire scl_fall = !scl && scl_d_r;
  wire bus_start = scl && scl_d_r && sda_d_r && !sda;
  wire bus_stop = scl && scl_d_r && !sda_d_r && sda;

  // Bus engine state
  i2cee_pkg::i2cee_bus_st_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic oe_r, oe_nxt;
  logic ackd_r, ackd_nxt;
  logic mack_r, mack_nxt;
  logic wp_lat_r, wp_lat_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [14:0] addr_r, addr_nxt;
  logic [8:0] page_r, page_nxt;
  logic push_v;
  logic prog_go;

  // Array and program engine state
  logic [37:0] mem [8192];
  logic [37:0] mem_q_r;
  logic [7:0] pbuf [64];
  logic [63:0] pmask_r;
  i2cee_pkg::i2cee_prog_st_t pst_r;
  logic [3:0] grp_r;
  logic [19:0] wcnt_r;
  logic [31:0] merged;

  i2cee_fifo_if #(.W(`I2CEE_FIFO_W)) fi ();

  i2cee_fifo #(.W(`I2CEE_FIFO_W), .D(`I2CEE_FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .f(fi.store)
  );

  wire busy = (pst_r != i2cee_pkg::PG_IDLE);
  wire dev_match = (sh_r[7:4] == `I2CEE_TYPE_CODE) && (sh_r[3:1] == cs_strap);
  wire byte_fall = scl_fall && (cnt_r == 4'h8);
  wire ack_fall = scl_fall && (cnt_r == 4'h9);
  wire [12:0] rd_grp = busy ? {page_r, grp_r} : addr_r[14:2];
  wire [31:0] fixed = ecc_fix(mem_q_r[31:0], mem_q_r[37:32]);
  wire [31:0] rd_sh = fixed >> {addr_r[1:0], 3'h0};
  wire [7:0] rd_byte = rd_sh[7:0];
  wire [3:0] grp_mask = pmask_r[{grp_r, 2'h0} +: 4];
  wire [5:0] pop_ofs = fi.pop_data[13:8];

  assign fi.push_valid = push_v;
  assign fi.push_data = {addr_r[5:0], sh_r};
  assign fi.pop_ready = (pst_r == i2cee_pkg::PG_IDLE) || (pst_r == i2cee_pkg::PG_DRAIN);
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign write_busy_o = busy;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    oe_nxt = oe_r;
    ackd_nxt = ackd_r;
    mack_nxt = mack_r;
    wp_lat_nxt = wp_lat_r;
    wr_pend_nxt = wr_pend_r;
    addr_nxt = addr_r;
    page_nxt = page_r;
    push_v = 1'b0;
    prog_go = 1'b0;
    if (bus_start) begin
      st_nxt = i2cee_pkg::ST_DEV;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt = i2cee_pkg::ST_IDLE;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      if (wr_pend_r) begin
        prog_go = 1'b1;
        wr_pend_nxt = 1'b0;
      end
    end else begin
      unique case (st_r)
        i2cee_pkg::ST_IDLE, i2cee_pkg::ST_HOLD: begin
        end
        i2cee_pkg::ST_RDAT: begin
          if (scl_rise) begin
            if (cnt_r == 4'h8) mack_nxt = !sda;
            if (cnt_r != 4'h9) cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall) begin
            if (cnt_r != 4'h0 && cnt_r < 4'h8) begin
              sh_nxt = {sh_r[6:0], 1'b1};
              oe_nxt = !sh_r[6];
            end else if (cnt_r == 4'h8) begin
              oe_nxt = 1'b0;
              addr_nxt = addr_r + 15'h1;
            end else if (cnt_r == 4'h9) begin
              cnt_nxt = 4'h0;
              if (mack_r) begin
                sh_nxt = rd_byte;
                oe_nxt = !rd_byte[7];
              end else begin
                st_nxt = i2cee_pkg::ST_HOLD;
              end
            end
          end
        end
        default: begin
          if (scl_rise) begin
            if (cnt_r < 4'h8) sh_nxt = {sh_r[6:0], sda};
            if (cnt_r != 4'h9) cnt_nxt = cnt_r + 4'h1;
          end
          if (byte_fall) begin
            ackd_nxt = 1'b1;
            if (st_r == i2cee_pkg::ST_DEV) begin
              ackd_nxt = dev_match && !busy;
            end else if (st_r == i2cee_pkg::ST_AHI) begin
              addr_nxt[14:8] = sh_r[6:0];
            end else if (st_r == i2cee_pkg::ST_ALO) begin
              addr_nxt[7:0] = sh_r;
            end else begin
              ackd_nxt = !wp_lat_r && fi.push_ready;
              if (!wp_lat_r && fi.push_ready) begin
                push_v = 1'b1;
                wr_pend_nxt = 1'b1;
                addr_nxt[5:0] = addr_r[5:0] + 6'h1;
              end
            end
            oe_nxt = ackd_nxt;
          end
          if (ack_fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            if (!ackd_r) begin
              st_nxt = i2cee_pkg::ST_HOLD;
            end else if (st_r == i2cee_pkg::ST_DEV) begin
              if (sh_r[0]) begin
                st_nxt = i2cee_pkg::ST_RDAT;
                sh_nxt = rd_byte;
                oe_nxt = !rd_byte[7];
                mack_nxt = 1'b0;
              end else begin
                st_nxt = i2cee_pkg::ST_AHI;
              end
            end else if (st_r == i2cee_pkg::ST_AHI) begin
              st_nxt = i2cee_pkg::ST_ALO;
            end else if (st_r == i2cee_pkg::ST_ALO) begin
              st_nxt = i2cee_pkg::ST_WDAT;
              wp_lat_nxt = wp_pin;
              page_nxt = addr_r[14:6];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= i2cee_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      ackd_r <= 1'b0;
      mack_r <= 1'b0;
      wp_lat_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_r <= 15'h0000;
      page_r <= 9'h000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      oe_r <= oe_nxt;
      ackd_r <= ackd_nxt;
      mack_r <= mack_nxt;
      wp_lat_r <= wp_lat_nxt;
      wr_pend_r <= wr_pend_nxt;
      addr_r <= addr_nxt;
      page_r <= page_nxt;
    end
  end

  // Group merge: buffered bytes replace the corrected stored ones
  always_comb begin
    merged = fixed;
    for (int i = 0; i < `I2CEE_GRP_BYTES; i++) begin
      if (grp_mask[i]) merged[8*i +: 8] = pbuf[{grp_r, 2'(i)}];
    end
  end

  initial begin
    for (int g = 0; g < 8192; g++) begin
      mem[g] = {ecc_gen(`I2CEE_ERASED_GRP), `I2CEE_ERASED_GRP};
    end
  end

  // Array port: one registered read and one write per cycle
  always_ff @(posedge ref_clk_i) begin
    mem_q_r <= mem[rd_grp];
    if (pst_r == i2cee_pkg::PG_MRG && grp_mask != 4'h0) begin
      mem[{page_r, grp_r}] <= {ecc_gen(merged), merged};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (fi.pop_ready && fi.pop_valid) pbuf[pop_ofs] <= fi.pop_data[7:0];
  end

  // Program engine; the bus is locked out by busy throughout
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pst_r <= i2cee_pkg::PG_IDLE;
      grp_r <= 4'h0;
      wcnt_r <= 20'h00000;
      pmask_r <= 64'h0;
    end else begin
      if (fi.pop_ready && fi.pop_valid) pmask_r[pop_ofs] <= 1'b1;
      unique case (pst_r)
        i2cee_pkg::PG_IDLE: begin
          if (prog_go) pst_r <= i2cee_pkg::PG_DRAIN;
        end
        i2cee_pkg::PG_DRAIN: begin
          if (!fi.pop_valid) begin
            pst_r <= i2cee_pkg::PG_RD;
            grp_r <= 4'h0;
          end
        end
        i2cee_pkg::PG_RD: begin
          pst_r <= i2cee_pkg::PG_MRG;
        end
        i2cee_pkg::PG_MRG: begin
          if (grp_r == 4'hf) begin
            pst_r <= i2cee_pkg::PG_WAIT;
            wcnt_r <= 20'h00000;
            pmask_r <= 64'h0;
          end else begin
            grp_r <= grp_r + 4'h1;
            pst_r <= i2cee_pkg::PG_RD;
          end
        end
        i2cee_pkg::PG_WAIT: begin
          wcnt_r <= wcnt_r + 20'h1;
          if (wcnt_r >= WR_LAST) pst_r <= i2cee_pkg::PG_IDLE;
        end
        default: begin
          pst_r <= i2cee_pkg::PG_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/i2cee_top_asserts.sv ====
// Port-level assertions for the two-wire serial EEPROM slave engine
`timescale 1ns/100ps
`default_nettype none
module i2cee_top_asserts #(
  parameter int WR_CYC = 1000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Straps and status
  input wire logic chip_select_inputs_i,
  input wire logic chip_select_inputs_mid_i,
  input wire logic chip_select_inputs_top_i,
  input wire logic write_protect_input_i,
  input wire logic write_busy_o
);
  logic sda_q_r;
  logic seen_r;
  int busy_cnt_r;
  // Pin-level START seen; the design sees it later through its synchronisers
  always_ff @(posedge ref_clk_i) begin
    sda_q_r <= sda_i;
    busy_cnt_r <= write_busy_o ? busy_cnt_r + 1 : 0;
    if (!rst_n_i) seen_r <= 1'b0;
    else if (scl_i && sda_q_r && !sda_i) seen_r <= 1'b1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  open_drain_a: assert property (sda_o == 1'b0) else $error("sda driven high");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=> !sda_oe_o && !write_busy_o)
    else $error("outputs active in reset");
  start_first_a: assert property ($rose(sda_oe_o) |-> seen_r) else $error("drive before START");
  drive_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 4))
    else $error("sda changed off scl low");
  drive_hold_a: assert property ($changed(sda_oe_o) |=> $stable(sda_oe_o) [*8])
    else $error("driven bit not held");
  busy_start_a: assert property ($rose(write_busy_o) |-> scl_i && sda_i && !sda_oe_o)
    else $error("busy without STOP");
  busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o) else $error("ack while busy");
  busy_len_a: assert property ($fell(write_busy_o) |-> busy_cnt_r >= WR_CYC && busy_cnt_r <= WR_CYC + 40)
    else $error("write cycle length wrong");
  cover property ($rose(write_busy_o));
  cover property ($fell(write_busy_o));
  cover property ($rose(sda_oe_o) && write_protect_input_i);
endmodule
bind i2cee_top i2cee_top_asserts #(.WR_CYC(WR_CYC)) chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .chip_select_inputs_i(chip_select_inputs_i), .chip_select_inputs_mid_i(chip_select_inputs_mid_i),
  .chip_select_inputs_top_i(chip_select_inputs_top_i), .write_protect_input_i(write_protect_input_i),
  .write_busy_o(write_busy_o));
`default_nettype wire

// ==== tb/i2cee_bus_master.sv ====
// Two-wire bus master model; link clock stands high between frames
`timescale 1ns/100ps
`default_nettype none
module i2cee_bus_master (
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Long low phase first, so a slave still holding ACK lets go before SCL rises
  task automatic start();
    sda_oe_o = 1'b0;
    #48 scl_o = 1'b1;
    #32 sda_oe_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  task automatic xbit(input logic b, output logic r);
    #16 sda_oe_o = ~b;
    #16 scl_o = 1'b1;
    #30 r = sda_i;
    #2 scl_o = 1'b0;
  endtask
  task automatic wb(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(v[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rb(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      v[i] = r;
    end
    xbit(~ack, r);
  endtask
  task automatic stop();
    #16 sda_oe_o = 1'b1;
    #32 scl_o = 1'b1;
    #32 sda_oe_o = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== tb/i2c_serial_eeprom_slave_tb_top.sv ====
// Testbench for the two-wire serial EEPROM slave engine
`timescale 1ns/100ps
`default_nettype none
module i2c_serial_eeprom_slave_tb_top;
  localparam int WRC = 200;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] cs = 3'h0;
  logic wp = 1'b0;
  logic dut_oe;
  logic m_oe;
  logic scl;
  logic busy;
  wire logic sda = ~(dut_oe | m_oe);
  int fails = 0;
  int num_checks = 0;
  logic [7:0] mem [int];
  logic a;
  logic [7:0] d;
  logic [15:0] base;
  i2cee_top #(.WR_CYC(WRC)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(dut_oe), .chip_select_inputs_i(cs[0]), .chip_select_inputs_mid_i(cs[1]),
    .chip_select_inputs_top_i(cs[2]), .write_protect_input_i(wp), .write_busy_o(busy));
  i2cee_bus_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // Unwritten bytes read as erased; top address bit is ignored
  function automatic logic [7:0] ex(input int ad);
    return mem.exists(ad & 32'h7fff) ? mem[ad & 32'h7fff] : 8'hff;
  endfunction
  task automatic dev(input logic rd);
    m.start();
    m.wb({4'ha, cs, rd}, a);
  endtask
  task automatic seta(input logic [15:0] ad);
    dev(1'b0);
    ck(a, 1);
    m.wb(ad[15:8], a);
    ck(a, 1);
    m.wb(ad[7:0], a);
    ck(a, 1);
  endtask
  task automatic rdq(input logic [15:0] ad, input int n);
    seta(ad);
    dev(1'b1);
    ck(a, 1);
    for (int i = 0; i < n; i++) begin
      m.rb(i < n - 1, d);
      ck(d, ex(ad + i));
    end
    m.stop();
  endtask
  // Bytes past the page end wrap and overwrite earlier ones
  task automatic wr(input logic [15:0] ad, input int n);
    logic [7:0] v;
    int k;
    seta(ad);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      m.wb(v, a);
      ck(a, !wp);
      k = (ad & 16'h7fc0) | ((ad + i) & 63);
      if (!wp) mem[k] = v;
    end
    m.stop();
    k = 0;
    do begin
      dev(1'b0);
      m.stop();
      if (k == 0) ck(a, wp);
      k++;
    end while (!a && k < 40);
    if (!a) begin
      fails++;
      $display("MISMATCH %0t write cycle never ended", $time);
      complete_run();
    end
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fails++;
    $display("MISMATCH %0t run timed out", $time);
    complete_run();
  end
  initial begin
    d = 8'($urandom(32'h7d80));
    cs = 3'($urandom);
    repeat (6) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    ck({dut_oe, busy}, 0);
    repeat (8) @(posedge ref_clk_i);
    // Link changes then fall on whole nanoseconds, never on a rising clock edge
    #1.5;
    m.wb({4'ha, cs, 1'b0}, a);
    m.stop();
    ck(a, 0);
    for (int k = 0; k < 4; k++) begin
      m.start();
      m.wb({4'ha, cs, 1'b0} ^ (8'h02 << k), a);
      m.stop();
      ck(a, 0);
    end
    base = {1'b0, 9'($urandom), 6'd60};
    wr(base, 70);
    rdq(base & 16'h7fc0, 64);
    repeat (3) begin
      base = 16'($urandom);
      wr(base, 1);
      dev(1'b1);
      ck(a, 1);
      m.rb(1'b0, d);
      m.stop();
      ck(d, ex((base & 16'h7fc0) | ((base + 1) & 63)));
      rdq(base & 16'hfffc, 4);
    end
    wp = 1'b1;
    wr(base, 2);
    wp = 1'b0;
    rdq(base, 2);
    wr(16'hffff, 1);
    rdq(16'hfffe, 3);
    complete_run();
  end
endmodule
`default_nettype wire
